/* pin_world.sv */
// Purpose: Board model that resolves pin levels from the drives and external pull-downs.
// Assumes: External parts only sink current; the pins never see a strong high from outside.
// Notes: A serial pin with neither drive nor pull shows the inverse of its last level; port pins read low.
`default_nettype none
module pin_world
	import port_pin_pkg::*;
(
	input wire logic clk,
	input wire port_drive_s up_drv,
	input wire port_drive_s alt_drv,
	input wire serial_drive_s ser_drv,
	input wire logic [7:0] up_low,
	input wire logic [7:0] alt_low,
	input wire logic [1:0] ser_low,
	output logic [7:0] up_pin,
	output logic [7:0] alt_pin,
	output logic [1:0] ser_pin
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] ser_last = 2'h3; // Last serial level, so a floating pin never looks stable.
	// Sample the serial lines each cycle for the floating case.
	always_ff @(posedge clk)
	begin
		ser_last <= ser_pin;
	end
	assign up_pin = ((up_drv.oe & up_drv.out) | (~up_drv.oe & up_drv.weak_pu)) & ~up_low;
	assign alt_pin = ((alt_drv.oe & alt_drv.out) | (~alt_drv.oe & alt_drv.weak_pu)) & ~alt_low;
	assign ser_pin = ((ser_drv.oe & ser_drv.out) | (~ser_drv.oe & ser_drv.weak_pu) |
		(~ser_drv.oe & ~ser_drv.weak_pu & ~ser_last)) & ~ser_low;
endmodule : pin_world
`default_nettype wire

/* port_pin_logic.sv */
// Purpose: Pin logic for the upper address port, the alternate-function port and serial pins.
// Assumes: Single 100 MHz clock, asynchronous active-low reset, pins sampled by two flops.
// Notes: Pin outputs use open-drain-with-pull modelling; oe high means strongly driven.
`default_nettype none

module port_pin_logic
	import port_pin_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// Core port access and returned read data.
	input wire port_access_s access,
	output logic [7:0] read_data,
	// External memory addressing.
	input wire logic ext_mem_drive, // External-memory drive select.
	input wire logic ext_data_24, // Access is to the 24-bit data space.
	input wire logic ext_addr_mid, // Middle byte phase of a 24-bit access.
	input wire logic [23:0] ext_addr,
	// Chip configuration register fields.
	input wire logic pwm_on_upper, // Route PWM to upper bits 6 and 7.
	input wire logic pwm_on_alt, // Route PWM to alternate bits 3 and 4.
	input wire logic [1:0] pwm_out, // PWM channel 0 and 1 levels.
	// Alternate-function outputs from peripherals (1 = release to latch).
	input wire logic uart_txd,
	input wire logic uart_rxd_out, // Data out in shift mode 0.
	input wire logic miso_out,
	input wire logic wr_strobe_n,
	input wire logic rd_strobe_n,
	// Alternate-function inputs to peripherals.
	output logic uart_rxd_in,
	output logic ext_interrupt_zero,
	output logic ext_interrupt_one,
	output logic timer_zero_input,
	output logic timer_one_input,
	output logic miso_in,
	// Serial pin control.
	input wire logic serial_periph_select, // 0 = I2C, 1 = SPI.
	input wire logic [1:0] spi_out, // SPI clock and data levels.
	input wire logic [1:0] spi_drive, // SPI strong drive request.
	input wire logic i2c_master, // I2C master mode.
	input wire logic [1:0] sw_serial_out, // Software pin levels.
	input wire logic [1:0] i2c_out, // I2C engine levels when not software driven.
	output logic [1:0] i2c_in, // Filtered clock and data to I2C logic.
	output logic [1:0] spi_in, // Synchronised clock and data to SPI logic.
	// Pins.
	input wire logic [7:0] upper_address_port_in,
	output port_drive_s upper_address_port_drv,
	input wire logic [7:0] alt_function_port_in,
	output port_drive_s alt_function_port_drv,
	input wire logic [1:0] serial_pin_in, // [0] serial_clock_pin, [1] serial_data_pin.
	output serial_drive_s serial_pin_drv
);

	// Port latches, one byte each.
	logic [7:0] upper_latch;
	logic [7:0] alt_latch;
	// Two-flop synchronisers for every pin.
	logic [7:0] upper_meta, upper_sync;
	logic [7:0] alt_meta, alt_sync;
	logic [1:0] ser_meta, ser_sync;
	// Glitch filter state per serial pin.
	logic [FILT_W-1:0] filt_cnt [2];
	logic [1:0] filt_val;
	// Combinational next values.
	logic [7:0] next_upper_pin, next_alt_pin;
	logic [7:0] next_upper_oe, next_alt_oe;
	logic [7:0] alt_func_level;
	logic [7:0] next_upper_latch, next_alt_latch;
	logic [7:0] src_byte;

	// Bit write helper: the whole byte is rewritten with one bit changed.
	function automatic logic [7:0] set_bit(input logic [7:0] b, input logic [2:0] i,
		input logic v);
		logic [7:0] r;
		r = b;
		r[i] = v;
		return r;
	endfunction : set_bit

	// Pins are asynchronous to the core, so two flops precede any use.
	// They reset to the pulled-up idle level so no false falling edge follows reset.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			upper_meta <= 8'hFF;
			upper_sync <= 8'hFF;
			alt_meta <= 8'hFF;
			alt_sync <= 8'hFF;
			ser_meta <= 2'h3;
			ser_sync <= 2'h3;
		end
		else if (clk_en)
		begin
			upper_meta <= upper_address_port_in;
			upper_sync <= upper_meta;
			alt_meta <= alt_function_port_in;
			alt_sync <= alt_meta;
			ser_meta <= serial_pin_in;
			ser_sync <= ser_meta;
		end
	end

	// Source byte and next latch values for core accesses.
	always_comb
	begin
		// Read-modify-write and bit ops start from the latch, not the pin.
		src_byte = (access.port == ACC_ALT) ? alt_latch : upper_latch;
		next_upper_latch = upper_latch;
		next_alt_latch = alt_latch;
		if (access.valid && access.write)
		begin
			if (access.port == ACC_ALT)
			begin
				next_alt_latch = access.bit_op ?
					set_bit(src_byte, access.bit_idx, access.bit_val) : access.wdata;
			end
			else
			begin
				next_upper_latch = access.bit_op ?
					set_bit(src_byte, access.bit_idx, access.bit_val) : access.wdata;
			end
		end
	end

	// Latches only change on core writes; memory mode never touches them.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			upper_latch <= LATCH_RESET;
			alt_latch <= LATCH_RESET;
		end
		else if (clk_en)
		begin
			upper_latch <= next_upper_latch;
			alt_latch <= next_alt_latch;
		end
	end

	// Read data: latch for read-modify-write and bit ops, synchronised pin otherwise.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			read_data <= 8'h00;
		end
		else if (clk_en && access.valid && !access.write)
		begin
			if (access.rmw || access.bit_op)
			begin
				read_data <= src_byte;
			end
			else
			begin
				read_data <= (access.port == ACC_ALT) ? alt_sync : upper_sync;
			end
		end
	end

	// Upper address port pin levels.
	always_comb
	begin
		if (ext_mem_drive)
		begin
			// Program fetch shows A15:8; 24-bit data access shows A23:16 then A15:8 in the middle byte phase.
			next_upper_pin = (ext_data_24 && !ext_addr_mid) ? ext_addr[23:16] : ext_addr[15:8];
			next_upper_oe = 8'hFF;
		end
		else
		begin
			// Latch one releases to the weak pull-up, zero drives low.
			next_upper_pin = upper_latch;
			next_upper_oe = ~upper_latch;
			if (pwm_on_upper)
			begin
				// PWM overrides the latch and drives push-pull.
				next_upper_pin[UP_PWM0] = pwm_out[0];
				next_upper_pin[UP_PWM1] = pwm_out[1];
				next_upper_oe[UP_PWM0] = 1'b1;
				next_upper_oe[UP_PWM1] = 1'b1;
			end
		end
	end

	// Alternate-function output levels; one means release, so idle bits sit high.
	always_comb
	begin
		alt_func_level = 8'hFF;
		alt_func_level[AF_RXD] = uart_rxd_out;
		alt_func_level[AF_TXD] = uart_txd;
		alt_func_level[AF_EXT_INTERRUPT_ONE] = miso_out;
		alt_func_level[AF_WR] = wr_strobe_n;
		alt_func_level[AF_RD] = rd_strobe_n;
		// The function only reaches the pin when the latch holds one.
		next_alt_pin = alt_latch & alt_func_level;
		next_alt_oe = ~next_alt_pin;
		if (pwm_on_alt)
		begin
			// PWM wins over any latch value on bits 3 and 4.
			next_alt_pin[AF_EXT_INTERRUPT_ONE] = pwm_out[1];
			next_alt_pin[AF_T0] = pwm_out[0];
			next_alt_oe[AF_EXT_INTERRUPT_ONE] = 1'b1;
			next_alt_oe[AF_T0] = 1'b1;
		end
	end

	// Port pin drivers are registered so every output comes from a flop.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			upper_address_port_drv <= '{out: 8'hFF, oe: 8'h00, weak_pu: 8'hFF};
			alt_function_port_drv <= '{out: 8'hFF, oe: 8'h00, weak_pu: 8'hFF};
		end
		else if (clk_en)
		begin
			upper_address_port_drv.out <= next_upper_pin;
			upper_address_port_drv.oe <= next_upper_oe;
			upper_address_port_drv.weak_pu <= 8'hFF;
			alt_function_port_drv.out <= next_alt_pin;
			alt_function_port_drv.oe <= next_alt_oe;
			alt_function_port_drv.weak_pu <= 8'hFF;
		end
	end

	// Alternate-function inputs to peripherals read the synchronised pins.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			uart_rxd_in <= 1'b1;
			ext_interrupt_zero <= 1'b1;
			ext_interrupt_one <= 1'b1;
			timer_zero_input <= 1'b1;
			timer_one_input <= 1'b1;
			miso_in <= 1'b1;
		end
		else if (clk_en)
		begin
			uart_rxd_in <= alt_sync[AF_RXD];
			ext_interrupt_zero <= alt_sync[AF_EXT_INTERRUPT_ZERO];
			ext_interrupt_one <= alt_sync[AF_EXT_INTERRUPT_ONE];
			timer_zero_input <= alt_sync[AF_T0];
			timer_one_input <= alt_sync[AF_T1];
			miso_in <= alt_sync[AF_EXT_INTERRUPT_ONE];
		end
	end

	// Glitch filter: a new level is accepted only after it has held past 50 ns.
	// The trade-off is a fixed added latency of the filter window on I2C edges.
	for (genvar g = 0; g < 2; g++)
	begin : gen_filter
		always_ff @(posedge clk or negedge reset_n)
		begin
			if (!reset_n)
			begin
				filt_cnt[g] <= '0;
				filt_val[g] <= 1'b1;
			end
			else if (clk_en)
			begin
				if (ser_sync[g] == filt_val[g])
				begin
					filt_cnt[g] <= '0;
				end
				else if (filt_cnt[g] == FILT_W'(GLITCH_CYCLES - 1))
				begin
					filt_val[g] <= ser_sync[g];
					filt_cnt[g] <= '0;
				end
				else
				begin
					filt_cnt[g] <= filt_cnt[g] + FILT_W'(1);
				end
			end
		end
	end

	// Serial pin drivers and conditioned inputs.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			serial_pin_drv <= '{out: 2'h3, oe: 2'h0, weak_pu: 2'h3};
			i2c_in <= 2'h3;
			spi_in <= 2'h3;
		end
		else if (clk_en)
		begin
			i2c_in <= filt_val;
			spi_in <= ser_sync;
			if (serial_periph_select)
			begin
				// SPI controls the strong pull-up: push-pull.
				serial_pin_drv.out <= spi_out;
				serial_pin_drv.oe <= spi_drive;
				serial_pin_drv.weak_pu <= 2'h0;
			end
			else
			begin
				// Only pull-downs drive; highs come from the weak pull-up.
				serial_pin_drv.weak_pu <= 2'h3;
				if (i2c_master)
				begin
					serial_pin_drv.out <= sw_serial_out;
					serial_pin_drv.oe <= ~sw_serial_out;
				end
				else
				begin
					serial_pin_drv.out <= i2c_out;
					serial_pin_drv.oe <= ~i2c_out;
				end
			end
		end
	end

endmodule : port_pin_logic
`default_nettype wire

/* port_pin_logic_checker.sv */
// Purpose: Assertions on pin drive and input filter timing of the port pin logic.
// Assumes: One clock; drive outputs are registered one cycle after their causes.
// Notes: Checks pause while reset or a low clock enable hold the state.
`default_nettype none
module port_pin_logic_checker
	import port_pin_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic ext_mem_drive,
	input wire logic ext_data_24,
	input wire logic ext_addr_mid,
	input wire logic [23:0] ext_addr,
	input wire logic pwm_on_upper,
	input wire logic pwm_on_alt,
	input wire logic [1:0] pwm_out,
	input wire logic serial_periph_select,
	input wire logic [1:0] spi_out,
	input wire logic [1:0] spi_drive,
	input wire logic [1:0] serial_pin_in,
	input wire logic [1:0] i2c_in,
	input wire port_drive_s upper_address_port_drv,
	input wire port_drive_s alt_function_port_drv,
	input wire serial_drive_s serial_pin_drv
);
	// A frozen clock enable would make every next-cycle relation stale.
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n || !clk_en);
	AST_UPPER_MID: assert property (ext_mem_drive && !pwm_on_upper &&
		!(ext_data_24 && !ext_addr_mid) |=> upper_address_port_drv.oe == 8'hFF &&
		upper_address_port_drv.out == $past(ext_addr[15:8])) else $error("upper mid byte wrong");
	AST_UPPER_HIGH: assert property (ext_mem_drive && !pwm_on_upper && ext_data_24 &&
		!ext_addr_mid |=> upper_address_port_drv.out == $past(ext_addr[23:16]))
		else $error("upper high byte wrong");
	AST_UPPER_PWM: assert property (pwm_on_upper && !ext_mem_drive |=>
		{upper_address_port_drv.oe[7:6],
		upper_address_port_drv.out[7:6]} == {2'h3, $past(pwm_out)}) else $error("upper pwm wrong");
	AST_ALT_PWM: assert property (pwm_on_alt |=> {alt_function_port_drv.oe[4:3],
		alt_function_port_drv.out[4:3]} == {2'h3, $past(pwm_out[0]), $past(pwm_out[1])})
		else $error("alternate pwm wrong");
	AST_ALT_OPEN: assert property (!pwm_on_alt |=> alt_function_port_drv.weak_pu == 8'hFF &&
		(alt_function_port_drv.oe & alt_function_port_drv.out) == 8'h00)
		else $error("alternate pin driven high");
	AST_I2C_OPEN: assert property (!serial_periph_select |=> serial_pin_drv.weak_pu == 2'h3 &&
		(serial_pin_drv.oe & serial_pin_drv.out) == 2'h0) else $error("serial pin not open drain");
	AST_SPI_DRIVE: assert property (serial_periph_select |=>
		serial_pin_drv == {$past(spi_out), $past(spi_drive), 2'h0}) else $error("spi drive wrong");
	// The filtered clock may only move to a level the pin showed both 4 and 7 cycles earlier.
	AST_FILTER: assert property ($changed(i2c_in[0]) |->
		$past(serial_pin_in[0], 4) == i2c_in[0] && $past(serial_pin_in[0], 7) == i2c_in[0])
		else $error("short pulse passed filter");
	COV_MEM: cover property (ext_mem_drive && ext_data_24);
	COV_PWM: cover property (pwm_on_upper && pwm_on_alt);
	COV_FILT: cover property ($fell(i2c_in[0]));
endmodule : port_pin_logic_checker
bind port_pin_logic port_pin_logic_checker u_chk (.clk, .reset_n, .clk_en, .ext_mem_drive,
	.ext_data_24, .ext_addr_mid, .ext_addr, .pwm_on_upper, .pwm_on_alt, .pwm_out,
	.serial_periph_select, .spi_out, .spi_drive, .serial_pin_in, .i2c_in,
	.upper_address_port_drv, .alt_function_port_drv, .serial_pin_drv);
`default_nettype wire

/* port_pin_logic_tb.sv */
// Purpose: Self-checking bench for the port pin logic.
// Assumes: Pins resolved by pin_world; clock enable held high except during one write.
// Notes: Expected values follow the latch, drive and filter behaviour only.
`default_nettype none
module port_pin_logic_tb
	import port_pin_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 0;
	logic reset_n = 0;
	port_access_s access = '0;
	logic [7:0] read_data, up_low = 8'h00, alt_low = 8'h00, up_pin, alt_pin;
	logic ext_mem_drive = 0, ext_data_24 = 0, ext_addr_mid = 0, pwm_on_upper = 0, pwm_on_alt = 0;
	logic [23:0] ext_addr = 24'hC3963C;
	logic [1:0] pwm_out = 2'h2, spi_out = 2'h1, spi_drive = 2'h3, sw_out = 2'h3;
	logic [1:0] i2c_in, spi_in, ser_low = 2'h0, ser_pin;
	logic serial_periph_select = 0, i2c_master = 1, clk_en = 1;
	logic [4:0] po = 5'h1F; // Peripheral outputs; a one releases the pin to its latch.
	wire [5:0] pi; // Miso, timer one, timer zero, interrupt one, interrupt zero, receive.
	port_drive_s up_drv, alt_drv;
	serial_drive_s ser_drv;
	int n_errors = 0, checks = 0, cyc = 0;
	port_pin_logic dut (.clk, .reset_n, .clk_en, .access, .read_data, .ext_mem_drive,
		.ext_data_24, .ext_addr_mid, .ext_addr, .pwm_on_upper, .pwm_on_alt, .pwm_out,
		.uart_txd(po[1]), .uart_rxd_out(po[0]), .miso_out(po[2]), .wr_strobe_n(po[3]),
		.rd_strobe_n(po[4]), .uart_rxd_in(pi[0]), .ext_interrupt_zero(pi[1]),
		.ext_interrupt_one(pi[2]), .timer_zero_input(pi[3]), .timer_one_input(pi[4]),
		.miso_in(pi[5]), .serial_periph_select, .spi_out, .spi_drive, .i2c_master,
		.sw_serial_out(sw_out), .i2c_out(2'h3), .i2c_in, .spi_in, .upper_address_port_in(up_pin),
		.upper_address_port_drv(up_drv), .alt_function_port_in(alt_pin),
		.alt_function_port_drv(alt_drv), .serial_pin_in(ser_pin), .serial_pin_drv(ser_drv));
	pin_world world (.clk, .up_drv, .alt_drv, .ser_drv, .up_low, .alt_low, .ser_low, .up_pin,
		.alt_pin, .ser_pin);
	// Free-running core clock.
	initial
	begin
		forever #5 clk = ~clk;
	end
	// A hang costs a mismatch and ends the run.
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_errors++;
			conclude();
		end
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	// One-cycle core access, then one idle cycle; read data is settled on return.
	// The idle cycle keeps a following call from raising valid in the step it fell.
	task automatic acc(input logic p, rmw, bop, wr, input logic [2:0] idx, input logic bv,
		input logic [7:0] wd);
		access = '{1'b1, p, rmw, bop, idx, bv, wr, wd};
		step(1);
		access.valid = 1'b0;
		step(1);
	endtask : acc
	task automatic chk(input logic [7:0] got, exp);
		checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("ERROR at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic conclude();
		if (n_errors == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude
	initial
	begin
		repeat (20) @(posedge clk);
		#1 reset_n = 1'b1;
		acc(ACC_ALT, 1, 0, 0, 3'h0, 0, 8'h00);
		chk(read_data, 8'hFF);
		chk(up_drv.weak_pu & ~up_drv.oe, 8'hFF);
		acc(ACC_UPPER, 0, 0, 1, 3'h0, 0, 8'h5A);
		step(1);
		chk(up_drv.oe & ~up_drv.out, 8'hA5);
		// An outside part pulls bit one low while its latch holds one.
		up_low = 8'h02;
		step(3);
		acc(ACC_UPPER, 0, 0, 0, 3'h0, 0, 8'h00);
		chk(read_data, 8'h58);
		acc(ACC_UPPER, 1, 0, 0, 3'h0, 0, 8'h00);
		chk(read_data, 8'h5A);
		acc(ACC_UPPER, 0, 1, 1, 3'h0, 1, 8'h00);
		acc(ACC_UPPER, 0, 1, 1, 3'h3, 0, 8'h00);
		acc(ACC_UPPER, 0, 1, 0, 3'h0, 0, 8'h00);
		chk(read_data, 8'h53);
		up_low = 8'h00;
		ext_mem_drive = 1;
		step(1);
		chk(up_drv.out, 8'h96);
		chk(up_drv.oe, 8'hFF);
		ext_data_24 = 1;
		step(1);
		chk(up_drv.out, 8'hC3);
		ext_addr_mid = 1;
		step(1);
		chk(up_drv.out, 8'h96);
		ext_mem_drive = 0;
		step(1);
		chk(up_drv.oe & ~up_drv.out, 8'hAC);
		acc(ACC_UPPER, 1, 0, 0, 3'h0, 0, 8'h00);
		chk(read_data, 8'h53);
		// A write while the clock enable is low must leave the latch alone.
		clk_en = 0;
		acc(ACC_UPPER, 0, 0, 1, 3'h0, 0, 8'h00);
		clk_en = 1;
		acc(ACC_UPPER, 1, 0, 0, 3'h0, 0, 8'h00);
		chk(read_data, 8'h53);
		pwm_on_upper = 1;
		pwm_on_alt = 1;
		step(1);
		chk({up_drv.oe[7:6], up_drv.out[7:6], 4'h0}, 8'hE0);
		chk({alt_drv.oe[4:3], alt_drv.out[4:3], 4'h0}, 8'hD0);
		pwm_on_upper = 0;
		pwm_on_alt = 0;
		acc(ACC_ALT, 0, 0, 1, 3'h0, 0, 8'h00);
		step(1);
		chk(alt_drv.oe & ~alt_drv.out, 8'hFF);
		acc(ACC_ALT, 0, 0, 1, 3'h0, 0, 8'hFF);
		// Each peripheral output in turn pulls only its own pin low.
		for (int i = 0; i < 5; i++)
		begin
			po = ~(5'h01 << i);
			step(1);
			chk(alt_drv.oe, 8'h01 << (i < 2 ? i : i == 2 ? 3 : i + 3));
		end
		po = 5'h1F;
		// Each pin in turn is pulled low from outside and read by its function inputs.
		for (int b = 0; b < 8; b++)
		begin
			alt_low = 8'h01 << b;
			step(4);
			chk({2'h0, pi}, {2'h0, ~{alt_low[3], alt_low[5:2], alt_low[0]}});
		end
		alt_low = 8'h00;
		sw_out = 2'h2;
		step(1);
		chk({4'h0, ser_drv.oe, ser_drv.weak_pu}, 8'h07);
		// Without master mode the engine, idle high here, owns the pins, not software.
		i2c_master = 0;
		step(1);
		chk({4'h0, ser_drv.oe, ser_drv.weak_pu}, 8'h03);
		serial_periph_select = 1;
		step(1);
		chk({2'h0, ser_drv}, 8'h1C);
		serial_periph_select = 0;
		sw_out = 2'h3;
		step(12);
		chk({6'h00, i2c_in}, 8'h03);
		// A 50 ns low pulse on the clock pin must not reach the filtered input.
		ser_low = 2'h1;
		step(5);
		ser_low = 2'h0;
		for (int i = 0; i < 12; i++)
		begin
			step(1);
			chk({6'h00, i2c_in}, 8'h03);
		end
		// A 60 ns pulse, one cycle past the window, must get through; SPI sees it unfiltered.
		ser_low = 2'h1;
		step(6);
		chk({6'h00, spi_in}, 8'h02);
		ser_low = 2'h0;
		step(3);
		chk({6'h00, i2c_in}, 8'h02);
		conclude();
	end
endmodule : port_pin_logic_tb
`default_nettype wire

/* port_pin_pkg.sv */
// Purpose: Shared constants and carrier types for the port pin logic.
// Assumes: 100 MHz core clock; eight-bit ports.
// Notes: Alternate-function bit positions and glitch filter timing live here.
`default_nettype none
package port_pin_pkg;
	// Port width and latch reset value.
	localparam int PORT_W = 8;
	localparam logic [7:0] LATCH_RESET = 8'hFF;
	// Clock period and glitch filter window.
	localparam int CLK_PERIOD_NS = 10;
	localparam int GLITCH_NS = 50;
	// Longest rejected pulse rounds down, then one more cycle to accept.
	localparam int GLITCH_CYCLES = (GLITCH_NS / CLK_PERIOD_NS) + 1;
	localparam int FILT_W = 4;
	// Alternate-function bit positions on the alternate-function port.
	localparam int AF_RXD = 0;
	localparam int AF_TXD = 1;
	localparam int AF_EXT_INTERRUPT_ZERO = 2;
	localparam int AF_EXT_INTERRUPT_ONE = 3;
	localparam int AF_T0 = 4;
	localparam int AF_T1 = 5;
	localparam int AF_WR = 6;
	localparam int AF_RD = 7;
	// Upper address port PWM bit positions.
	localparam int UP_PWM0 = 6;
	localparam int UP_PWM1 = 7;
	// Port select codes for core access.
	localparam logic ACC_UPPER = 1'b0;
	localparam logic ACC_ALT = 1'b1;

	// Core access to a port: write, latch-read or pin-read, bit ops.
	typedef struct packed {
		logic valid; // Access strobe.
		logic port; // Port select.
		logic rmw; // Read-modify-write: read the latch.
		logic bit_op; // Single-bit write.
		logic [2:0] bit_idx; // Addressed bit.
		logic bit_val; // Bit value for bit ops.
		logic write; // Write back.
		logic [7:0] wdata; // Byte written on byte writes.
	} port_access_s;

	// Per-pin drive: output value, strong drive enable, weak pull enable.
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
		logic [7:0] weak_pu;
	} port_drive_s;

	// Serial pin drive for clock and data.
	typedef struct packed {
		logic [1:0] out;
		logic [1:0] oe;
		logic [1:0] weak_pu;
	} serial_drive_s;
endpackage : port_pin_pkg
`default_nettype wire
